// >>> pnp_regs.svh
`ifndef PNP_REGS_SVH
`define PNP_REGS_SVH
`define PNP_CMD_ERASE  8'h80
`define PNP_CMD_WFUSE  8'h40
`define PNP_CMD_WLOCK  8'h20
`define PNP_CMD_WFLASH 8'h10
`define PNP_CMD_WEE    8'h11
`define PNP_CMD_RSIG   8'h08
`define PNP_CMD_RFUSE  8'h04
`define PNP_CMD_RFLASH 8'h02
`define PNP_CMD_REE    8'h03
`define PNP_CMD_NOP    8'h00
`define PNP_ACT_ADDR   2'h0
`define PNP_ACT_DATA   2'h1
`define PNP_ACT_CMD    2'h2
`define PNP_WSEL_LO    2'h0
`define PNP_WSEL_HI    2'h1
`define PNP_WSEL_EXT   2'h2
`define PNP_RSEL_LO    2'h0
`define PNP_RSEL_LOCK  2'h1
`define PNP_RSEL_EXT   2'h2
`define PNP_RSEL_HI    2'h3
`define PNP_ERASED     8'hff
`define PNP_SIG_CNT    8'h03
`define PNP_CLK_NS     100
`define PNP_T_PROG_NS  3700000
`define PNP_T_ERASE_NS 7500000
`endif

// >>> pnp_pkg.sv
`default_nettype none
package pnp_pkg;
  typedef enum logic [2:0] {
    pnp_s_idle,
    pnp_s_erase,
    pnp_s_lkclr,
    pnp_s_prog_fl,
    pnp_s_prog_ee,
    pnp_s_fuse,
    pnp_s_wait
  } pnp_state_t;
endpackage
`default_nettype wire

// >>> pnp_port.sv
`timescale 1ns/1ns
`include "pnp_regs.svh"
`default_nettype none
module pnp_port #(
  parameter int          FLASH_AW   = 16,
  parameter int          PAGE_WB    = 7,
  parameter int          EE_AW      = 12,
  parameter int          EE_PAGE_WB = 3,
  parameter int          TW         = 17,
  parameter int unsigned PROG_CYC   =
    (`PNP_T_PROG_NS + `PNP_CLK_NS - 1) / `PNP_CLK_NS,
  parameter int unsigned ERASE_CYC  =
    (`PNP_T_ERASE_NS + `PNP_CLK_NS - 1) / `PNP_CLK_NS,
  parameter int          EEPRES_BIT = 3,
  parameter logic [7:0]  FUSE_LO_RST = 8'hff,
  parameter logic [7:0]  FUSE_HI_RST = 8'hff,
  parameter logic [7:0]  FUSE_EX_RST = 8'hff,
  // Identity and calibration values are arbitrary
  parameter logic [7:0]  SIG0 = 8'h5a,
  parameter logic [7:0]  SIG1 = 8'h11,
  parameter logic [7:0]  SIG2 = 8'h22,
  parameter logic [7:0]  CAL0 = 8'h80,
  parameter logic [7:0]  CAL1 = 8'h81,
  parameter logic [7:0]  CAL2 = 8'h82,
  parameter logic [7:0]  CAL3 = 8'h83
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       load_strobe_pin,
  input  wire logic       strobe_action_hi,
  input  wire logic       strobe_action_lo,
  input  wire logic       byte_select_one,
  input  wire logic       byte_select_two,
  input  wire logic       page_load_strobe,
  input  wire logic       write_n,
  input  wire logic       out_enable_n,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            ready_busy_out,
  output logic      [7:0] fuse_low,
  output logic      [7:0] fuse_high,
  output logic      [7:0] fuse_ext,
  output logic      [7:0] lock_bits,
  output logic            eeprom_preserve_fuse
);
  localparam int FW = 1 + PAGE_WB + 16;

  typedef struct packed {
    pnp_pkg::pnp_state_t st;
    logic [7:0]          cmd;
    logic [7:0]          addr_lo;
    logic [7:0]          addr_hi;
    logic [7:0]          dat_lo;
    logic [7:0]          dat_hi;
    logic [7:0]          fuse_lo;
    logic [7:0]          fuse_hi;
    logic [7:0]          fuse_ex;
    logic [7:0]          lock;
    logic [7:0]          dout;
    logic                ls_p;
    logic                wr_p;
    logic                pl_p;
    logic                armed;
    logic                pend;
    logic [1:0]          sel;
    logic [TW-1:0]       tmr;
    logic [FLASH_AW-1:0] swp;
    logic [FW-1:0]       f0;
    logic [FW-1:0]       f1;
    logic [1:0]          fn;
  } pnp_st_t;

  pnp_st_t r_q;
  pnp_st_t r_d;

  logic [1:0]          rs_q;
  logic                rst_sync_b;
  logic [15:0]         fl_mem [2**FLASH_AW];
  logic [7:0]          ee_mem [2**EE_AW];
  logic [15:0]         pf_mem [2**PAGE_WB];
  logic [7:0]          pe_mem [2**EE_PAGE_WB];
  logic                fl_we;
  logic [FLASH_AW-1:0] fl_wa;
  logic [15:0]         fl_wd;
  logic                ee_we;
  logic [EE_AW-1:0]    ee_wa;
  logic [7:0]          ee_wd;
  logic                pf_we;
  logic [PAGE_WB-1:0]  pf_wa;
  logic [15:0]         pf_wd;
  logic                pe_we;
  logic [EE_PAGE_WB-1:0] pe_wa;
  logic [7:0]          pe_wd;
  logic [15:0]         full_addr;
  logic [FLASH_AW-1:0] faddr;
  logic [EE_AW-1:0]    eaddr;
  logic                busy;
  logic                ls_rise;
  logic                pl_rise;
  logic                wr_fall;
  logic                push;
  logic                pop;
  logic                tgt_ok;
  logic                op_ok;
  logic [FW-1:0]       entry;
  logic [FW-1:0]       head;

  function automatic logic is_write(input logic [7:0] c);
    is_write = (c == `PNP_CMD_ERASE) || (c == `PNP_CMD_WFUSE) ||
               (c == `PNP_CMD_WLOCK) || (c == `PNP_CMD_WFLASH) ||
               (c == `PNP_CMD_WEE);
  endfunction

  function automatic logic [7:0] sig_byte(input logic [7:0] a);
    case (a[1:0])
      2'h0:    sig_byte = SIG0;
      2'h1:    sig_byte = SIG1;
      default: sig_byte = SIG2;
    endcase
  endfunction

  function automatic logic [7:0] cal_byte(input logic [1:0] a);
    case (a)
      2'h0:    cal_byte = CAL0;
      2'h1:    cal_byte = CAL1;
      2'h2:    cal_byte = CAL2;
      default: cal_byte = CAL3;
    endcase
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_sync_b = rs_q[1];

  assign full_addr = {r_q.addr_hi, r_q.addr_lo};
  assign faddr     = full_addr[FLASH_AW-1:0];
  assign eaddr     = full_addr[EE_AW-1:0];
  assign head      = r_q.f0;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    r_d   = r_q;
    fl_we = 1'b0;
    fl_wa = '0;
    fl_wd = '0;
    ee_we = 1'b0;
    ee_wa = '0;
    ee_wd = '0;
    pf_we = 1'b0;
    pf_wa = '0;
    pf_wd = '0;
    pe_we = 1'b0;
    pe_wa = '0;
    pe_wd = '0;
    r_d.ls_p = load_strobe_pin;
    r_d.wr_p = write_n;
    r_d.pl_p = page_load_strobe;
    ls_rise = load_strobe_pin & ~r_q.ls_p;
    pl_rise = page_load_strobe & ~r_q.pl_p;
    wr_fall = ~write_n & r_q.wr_p;
    busy    = (r_q.st != pnp_pkg::pnp_s_idle) | r_q.pend;

    // Strobe loads; registers hold until reloaded
    if (ls_rise && !busy) begin
      case ({strobe_action_hi, strobe_action_lo})
        `PNP_ACT_ADDR: begin
          if (byte_select_one) begin
            r_d.addr_hi = data_in;
          end else begin
            r_d.addr_lo = data_in;
          end
        end
        `PNP_ACT_DATA: begin
          if (byte_select_one) begin
            r_d.dat_hi = data_in;
          end else begin
            r_d.dat_lo = data_in;
          end
        end
        `PNP_ACT_CMD: begin
          r_d.cmd   = data_in;
          r_d.armed = is_write(data_in);
        end
        default: ;
      endcase
    end

    // Page-load buffer; drained only while idle
    pop    = (r_q.st == pnp_pkg::pnp_s_idle) && (r_q.fn != 2'h0);
    tgt_ok = ((r_q.cmd == `PNP_CMD_WFLASH) && byte_select_one) ||
             (r_q.cmd == `PNP_CMD_WEE);
    push   = pl_rise && r_q.armed && tgt_ok &&
             ((r_q.fn != 2'h2) || pop);
    entry  = {r_q.cmd == `PNP_CMD_WEE, r_q.addr_lo[PAGE_WB-1:0],
              r_q.dat_hi, r_q.dat_lo};
    if (pop) begin
      if (head[FW-1]) begin
        pe_we = 1'b1;
        pe_wa = head[16 +: EE_PAGE_WB];
        pe_wd = head[7:0];
      end else begin
        pf_we = 1'b1;
        pf_wa = head[16 +: PAGE_WB];
        pf_wd = head[15:0];
      end
    end
    case ({push, pop})
      2'b10: begin
        if (r_q.fn == 2'h0) begin
          r_d.f0 = entry;
        end else begin
          r_d.f1 = entry;
        end
        r_d.fn = r_q.fn + 2'h1;
      end
      2'b01: begin
        r_d.f0 = r_q.f1;
        r_d.fn = r_q.fn - 2'h1;
      end
      2'b11: begin
        if (r_q.fn == 2'h1) begin
          r_d.f0 = entry;
        end else begin
          r_d.f0 = r_q.f1;
          r_d.f1 = entry;
        end
      end
      default: ;
    endcase

    // Write pulse qualification
    case (r_q.cmd)
      `PNP_CMD_ERASE:  op_ok = 1'b1;
      `PNP_CMD_WFLASH: op_ok = !byte_select_one;
      `PNP_CMD_WEE:    op_ok = !byte_select_one;
      `PNP_CMD_WFUSE:  op_ok = {byte_select_two, byte_select_one} != 2'h3;
      `PNP_CMD_WLOCK:  op_ok = 1'b1;
      default:         op_ok = 1'b0;
    endcase
    if (wr_fall && !busy && r_q.armed && op_ok) begin
      r_d.pend = 1'b1;
      r_d.sel  = {byte_select_two, byte_select_one};
    end

    if (r_q.st != pnp_pkg::pnp_s_idle && r_q.tmr != '0) begin
      r_d.tmr = r_q.tmr - 1'b1;
    end

    case (r_q.st)
      pnp_pkg::pnp_s_idle: begin
        if (r_q.pend && r_q.fn == 2'h0 && !push) begin
          r_d.pend = 1'b0;
          r_d.swp  = '0;
          r_d.tmr  = TW'(PROG_CYC - 1);
          case (r_q.cmd)
            `PNP_CMD_ERASE: begin
              r_d.st  = pnp_pkg::pnp_s_erase;
              r_d.tmr = TW'(ERASE_CYC - 1);
            end
            `PNP_CMD_WFLASH: r_d.st = pnp_pkg::pnp_s_prog_fl;
            `PNP_CMD_WEE:    r_d.st = pnp_pkg::pnp_s_prog_ee;
            default:         r_d.st = pnp_pkg::pnp_s_fuse;
          endcase
        end
      end
      pnp_pkg::pnp_s_erase: begin
        fl_we = 1'b1;
        fl_wa = r_q.swp;
        fl_wd = {`PNP_ERASED, `PNP_ERASED};
        ee_wa = r_q.swp[EE_AW-1:0];
        ee_wd = `PNP_ERASED;
        ee_we = (r_q.swp[FLASH_AW-1:EE_AW] == '0) &&
                r_q.fuse_hi[EEPRES_BIT];
        r_d.swp = r_q.swp + 1'b1;
        if (&r_q.swp) begin
          r_d.st = pnp_pkg::pnp_s_lkclr;
        end
      end
      pnp_pkg::pnp_s_lkclr: begin
        r_d.lock = `PNP_ERASED;
        r_d.st   = pnp_pkg::pnp_s_wait;
      end
      pnp_pkg::pnp_s_prog_fl: begin
        fl_we = 1'b1;
        fl_wa = {faddr[FLASH_AW-1:PAGE_WB], r_q.swp[PAGE_WB-1:0]};
        fl_wd = pf_mem[r_q.swp[PAGE_WB-1:0]];
        r_d.swp = r_q.swp + 1'b1;
        if (&r_q.swp[PAGE_WB-1:0]) begin
          r_d.st = pnp_pkg::pnp_s_wait;
        end
      end
      pnp_pkg::pnp_s_prog_ee: begin
        ee_we = 1'b1;
        ee_wa = {eaddr[EE_AW-1:EE_PAGE_WB], r_q.swp[EE_PAGE_WB-1:0]};
        ee_wd = pe_mem[r_q.swp[EE_PAGE_WB-1:0]];
        r_d.swp = r_q.swp + 1'b1;
        if (&r_q.swp[EE_PAGE_WB-1:0]) begin
          r_d.st = pnp_pkg::pnp_s_wait;
        end
      end
      pnp_pkg::pnp_s_fuse: begin
        if (r_q.cmd == `PNP_CMD_WLOCK) begin
          r_d.lock = r_q.lock & r_q.dat_lo;
        end else begin
          case (r_q.sel)
            `PNP_WSEL_LO:  r_d.fuse_lo = r_q.dat_lo;
            `PNP_WSEL_HI:  r_d.fuse_hi = r_q.dat_lo;
            `PNP_WSEL_EXT: r_d.fuse_ex = r_q.dat_lo;
            default: ;
          endcase
        end
        r_d.st = pnp_pkg::pnp_s_wait;
      end
      pnp_pkg::pnp_s_wait: begin
        if (r_q.tmr == '0) begin
          r_d.st = pnp_pkg::pnp_s_idle;
        end
      end
      default: r_d.st = pnp_pkg::pnp_s_idle;
    endcase

    // Read data selection
    case (r_q.cmd)
      `PNP_CMD_RFLASH: begin
        r_d.dout = byte_select_one ? fl_mem[faddr][15:8] : fl_mem[faddr][7:0];
      end
      `PNP_CMD_REE: r_d.dout = ee_mem[eaddr];
      `PNP_CMD_RFUSE: begin
        case ({byte_select_two, byte_select_one})
          `PNP_RSEL_LO:   r_d.dout = r_q.fuse_lo;
          `PNP_RSEL_HI:   r_d.dout = r_q.fuse_hi;
          `PNP_RSEL_EXT:  r_d.dout = r_q.fuse_ex;
          default:        r_d.dout = r_q.lock;
        endcase
      end
      `PNP_CMD_RSIG: begin
        if (byte_select_one) begin
          r_d.dout = cal_byte(r_q.addr_lo[1:0]);
        end else if (r_q.addr_lo < `PNP_SIG_CNT) begin
          r_d.dout = sig_byte(r_q.addr_lo);
        end else begin
          r_d.dout = `PNP_ERASED;
        end
      end
      default: r_d.dout = `PNP_ERASED;
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      r_q         <= '0;
      r_q.ls_p    <= 1'b1;
      r_q.wr_p    <= 1'b1;
      r_q.pl_p    <= 1'b1;
      r_q.fuse_lo <= FUSE_LO_RST;
      r_q.fuse_hi <= FUSE_HI_RST;
      r_q.fuse_ex <= FUSE_EX_RST;
      r_q.lock    <= `PNP_ERASED;
      r_q.dout    <= `PNP_ERASED;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------
  // Arrays (contents undefined until written)
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (fl_we) begin
      fl_mem[fl_wa] <= fl_wd;
    end
    if (ee_we) begin
      ee_mem[ee_wa] <= ee_wd;
    end
    if (pf_we) begin
      pf_mem[pf_wa] <= pf_wd;
    end
    if (pe_we) begin
      pe_mem[pe_wa] <= pe_wd;
    end
  end

  assign data_out       = r_q.dout;
  assign data_oe        = ~out_enable_n;
  assign ready_busy_out = ~busy;
  assign fuse_low       = r_q.fuse_lo;
  assign fuse_high      = r_q.fuse_hi;
  assign fuse_ext       = r_q.fuse_ex;
  assign lock_bits      = r_q.lock;
  assign eeprom_preserve_fuse = ~r_q.fuse_hi[EEPRES_BIT];
endmodule // pnp_port
`default_nettype wire

// >>> pnp_port_properties.sv
`timescale 1ns/1ns
`default_nettype none
module pnp_port_checker #(
  parameter int unsigned PROG_CYC   = 200,
  parameter int unsigned ERASE_CYC  = 300,
  parameter int          EEPRES_BIT = 3,
  parameter logic [7:0]  SIG0       = 8'h5a
) (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       load_strobe_pin,
  input wire logic       strobe_action_hi,
  input wire logic       strobe_action_lo,
  input wire logic       byte_select_one,
  input wire logic       write_n,
  input wire logic       out_enable_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic       ready_busy_out,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [7:0] lock_bits,
  input wire logic       eeprom_preserve_fuse
);
  // ----------------------------------------
  // Shadow of loaded command and address
  // ----------------------------------------
  logic        ld_q;
  logic [7:0]  cmd_q;
  logic [7:0]  alo_q;
  int unsigned busy_q;
  logic        ld_rise;
  logic        wr_arm;
  assign ld_rise = load_strobe_pin && !ld_q && ready_busy_out;
  assign wr_arm = cmd_q inside {8'h80, 8'h20} || (cmd_q[7:1] == 7'h08 && !byte_select_one);
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ld_q   <= 1'b1;
      cmd_q  <= 8'h00;
      alo_q  <= 8'h00;
      busy_q <= 0;
    end else begin
      ld_q   <= load_strobe_pin;
      busy_q <= ready_busy_out ? 0 : busy_q + 1;
      if (ld_rise && {strobe_action_hi, strobe_action_lo} == 2'h2)
        cmd_q <= data_in;
      if (ld_rise && {strobe_action_hi, strobe_action_lo} == 2'h0 && !byte_select_one)
        alo_q <= data_in;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_sig;
    (cmd_q == 8'h08 && !out_enable_n && !byte_select_one && alo_q == 8'h00) [*3];
  endsequence
  property p_oe; data_oe == !out_enable_n; endproperty
  property p_wr_busy; $fell(write_n) && ready_busy_out && wr_arm |=> !ready_busy_out; endproperty
  property p_wr_idle;
    $fell(write_n) && ready_busy_out && cmd_q inside {8'h02, 8'h03, 8'h04, 8'h08}
      |=> ready_busy_out;
  endproperty
  property p_nop; $fell(write_n) && ready_busy_out && cmd_q == 8'h00 |=> ready_busy_out [*2];
  endproperty
  property p_busy_min; $fell(ready_busy_out) |-> !ready_busy_out [*8]; endproperty
  property p_prog_len; $rose(ready_busy_out) && cmd_q != 8'h80 |-> busy_q >= PROG_CYC - 1;
  endproperty
  property p_erase_len; $rose(ready_busy_out) && cmd_q == 8'h80 |-> busy_q >= ERASE_CYC - 1;
  endproperty
  property p_lock_set; (lock_bits & ~$past(lock_bits)) != 8'h00 |-> cmd_q == 8'h80; endproperty
  property p_fuse_keep; !$stable(fuse_low) || !$stable(fuse_high) |-> cmd_q == 8'h40; endproperty
  property p_preserve; eeprom_preserve_fuse == !fuse_high[EEPRES_BIT]; endproperty
  property p_sig; s_sig |=> data_out == SIG0; endproperty
  a_oe: assert property (p_oe) else $error("bus enable wrong");
  a_wr_busy: assert property (p_wr_busy) else $error("no busy after write");
  a_wr_idle: assert property (p_wr_idle) else $error("unarmed write went busy");
  a_nop: assert property (p_nop) else $error("write after nop went busy");
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  a_prog_len: assert property (p_prog_len) else $error("program time short");
  a_erase_len: assert property (p_erase_len) else $error("erase time short");
  a_lock_set: assert property (p_lock_set) else $error("lock cleared outside erase");
  a_fuse_keep: assert property (p_fuse_keep) else $error("fuse changed");
  a_preserve: assert property (p_preserve) else $error("preserve flag wrong");
  a_sig: assert property (p_sig) else $error("signature byte wrong");
  c_erase: cover property ($fell(write_n) && ready_busy_out && cmd_q == 8'h80);
  c_flash: cover property ($fell(write_n) && ready_busy_out && cmd_q == 8'h10);
  c_sig: cover property (s_sig);
endmodule // pnp_port_checker
bind pnp_port pnp_port_checker #(
  .PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC), .EEPRES_BIT(EEPRES_BIT), .SIG0(SIG0)
) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .load_strobe_pin(load_strobe_pin),
  .strobe_action_hi(strobe_action_hi), .strobe_action_lo(strobe_action_lo),
  .byte_select_one(byte_select_one), .write_n(write_n), .out_enable_n(out_enable_n),
  .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .ready_busy_out(ready_busy_out), .fuse_low(fuse_low), .fuse_high(fuse_high),
  .lock_bits(lock_bits), .eeprom_preserve_fuse(eeprom_preserve_fuse)
);
`default_nettype wire

// >>> pnp_prog_model.sv
`timescale 1ns/1ns
`default_nettype none
module pnp_prog_model (
  input  wire logic       clk_sys,
  input  wire logic       ready_busy_out,
  input  wire logic       data_oe,
  input  wire logic [7:0] data_out,
  output var  logic       load_strobe_pin,
  output var  logic       strobe_action_hi,
  output var  logic       strobe_action_lo,
  output var  logic       byte_select_one,
  output var  logic       byte_select_two,
  output var  logic       page_load_strobe,
  output var  logic       write_n,
  output var  logic       out_enable_n,
  output var  logic [7:0] data_in
);
  // ----------------------------------------
  // Programmer strobes
  // ----------------------------------------
  initial begin
    // Strobes idle low so the first pulse is a real rising edge
    {load_strobe_pin, strobe_action_hi, strobe_action_lo, page_load_strobe} = 4'h6;
    {byte_select_one, byte_select_two, write_n, out_enable_n} = 4'h3;
    data_in = 8'h00;
  end
  task automatic ld(input logic [1:0] act, input logic bs1, input logic [7:0] val);
    @(posedge clk_sys);
    {strobe_action_hi, strobe_action_lo} <= act;
    byte_select_one <= bs1;
    data_in <= val;
    @(posedge clk_sys);
    load_strobe_pin <= 1'b1;
    @(posedge clk_sys);
    load_strobe_pin <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic pg(input logic bs1);
    @(posedge clk_sys);
    byte_select_one <= bs1;
    @(posedge clk_sys);
    page_load_strobe <= 1'b1;
    @(posedge clk_sys);
    page_load_strobe <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic bs2, input logic bs1, output int n);
    @(posedge clk_sys);
    byte_select_two <= bs2;
    byte_select_one <= bs1;
    @(posedge clk_sys);
    write_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    write_n <= 1'b1;
    n = 0;
    @(negedge clk_sys);
    while (ready_busy_out !== 1'b1 && n < 5000) begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    byte_select_two <= 1'b0;
    byte_select_one <= 1'b0;
  endtask
  task automatic rd(input logic bs2, input logic bs1, output logic [7:0] v, output logic o);
    @(posedge clk_sys);
    {byte_select_two, byte_select_one} <= {bs2, bs1};
    out_enable_n <= 1'b0;
    data_in <= ~data_in;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    v = data_out;
    o = data_oe;
    @(posedge clk_sys);
    out_enable_n <= 1'b1;
    @(negedge clk_sys);
  endtask
endmodule // pnp_prog_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int unsigned PROG = 200;
  localparam int unsigned ERAS = 300;
  // Identity and calibration values are arbitrary
  localparam logic [7:0] SIGB = 8'h3c;
  localparam logic [7:0] CALB = 8'h70;
  logic clk_sys, rst_b;
  logic lsp, sah, sal, bs1, bs2, pls, wr_n, oe_n, oe, rdy, eep;
  logic [7:0] din, dout, f_lo, f_hi, f_ex, lock;
  int bad_count, comparisons;
  pnp_port #(.FLASH_AW(10), .EE_AW(8), .PROG_CYC(PROG), .ERASE_CYC(ERAS),
    .SIG0(SIGB), .SIG1(SIGB + 8'h11), .SIG2(SIGB + 8'h22),
    .CAL0(CALB), .CAL1(CALB + 8'h01), .CAL2(CALB + 8'h02), .CAL3(CALB + 8'h03)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .load_strobe_pin(lsp), .strobe_action_hi(sah),
    .strobe_action_lo(sal), .byte_select_one(bs1), .byte_select_two(bs2),
    .page_load_strobe(pls), .write_n(wr_n), .out_enable_n(oe_n), .data_in(din),
    .data_out(dout), .data_oe(oe), .ready_busy_out(rdy), .fuse_low(f_lo),
    .fuse_high(f_hi), .fuse_ext(f_ex), .lock_bits(lock), .eeprom_preserve_fuse(eep));
  pnp_prog_model prg (
    .clk_sys(clk_sys), .ready_busy_out(rdy), .data_oe(oe), .data_out(dout),
    .load_strobe_pin(lsp), .strobe_action_hi(sah), .strobe_action_lo(sal),
    .byte_select_one(bs1), .byte_select_two(bs2), .page_load_strobe(pls),
    .write_n(wr_n), .out_enable_n(oe_n), .data_in(din));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic rdc(input string nm, input logic b2, input logic b1, input logic [7:0] exp);
    logic [7:0] v;
    logic       o;
    prg.rd(b2, b1, v, o);
    chk(nm, exp, v);
    chk("bus enable", 8'h01, {7'h0, o});
    chk("bus release", 8'h00, {7'h0, oe});
  endtask
  task automatic wrc(input string nm, input logic b2, input logic b1, input int unsigned min);
    int n;
    prg.wr(b2, b1, n);
    chk(nm, 8'h01, {7'h0, (min == 0) ? (n == 0) : (n >= int'(min) && n < 5000)});
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_erase(input logic [7:0] fh);
    prg.ld(2'h2, 1'b0, 8'h80);
    wrc("erase busy", 1'b0, 1'b0, ERAS);
    chk("lock after erase", 8'hff, lock);
    chk("fuse after erase", fh, f_hi);
  endtask
  task automatic t_flash();
    prg.ld(2'h2, 1'b0, 8'h02);
    wrc("unarmed write", 1'b0, 1'b0, 0);
    chk("unarmed ready", 8'h01, {7'h0, rdy});
    prg.ld(2'h2, 1'b0, 8'h10);
    prg.ld(2'h0, 1'b0, 8'h85);
    prg.ld(2'h1, 1'b0, 8'h34);
    prg.ld(2'h1, 1'b1, 8'h12);
    prg.pg(1'b1);
    prg.ld(2'h0, 1'b0, 8'h86);
    prg.ld(2'h1, 1'b0, 8'h78);
    prg.ld(2'h1, 1'b1, 8'h56);
    prg.pg(1'b1);
    prg.ld(2'h0, 1'b1, 8'h01);
    wrc("flash busy", 1'b0, 1'b0, PROG - 2);
    prg.ld(2'h2, 1'b0, 8'h00);
    wrc("nop write", 1'b0, 1'b0, 0);
    chk("nop ready", 8'h01, {7'h0, rdy});
    prg.ld(2'h2, 1'b0, 8'h02);
    prg.ld(2'h0, 1'b0, 8'h85);
    rdc("flash lo", 1'b0, 1'b0, 8'h34);
    rdc("flash hi", 1'b0, 1'b1, 8'h12);
    prg.ld(2'h0, 1'b0, 8'h86);
    rdc("flash next", 1'b0, 1'b1, 8'h56);
    prg.ld(2'h0, 1'b0, 8'h06);
    rdc("other page", 1'b0, 1'b0, 8'hff);
  endtask
  task automatic t_ee();
    prg.ld(2'h2, 1'b0, 8'h11);
    prg.ld(2'h0, 1'b1, 8'h00);
    prg.ld(2'h0, 1'b0, 8'h0a);
    prg.ld(2'h1, 1'b0, 8'h5c);
    prg.pg(1'b0);
    wrc("eeprom busy", 1'b0, 1'b0, PROG - 2);
    prg.ld(2'h2, 1'b0, 8'h03);
    rdc("eeprom", 1'b0, 1'b0, 8'h5c);
  endtask
  task automatic t_fuse();
    prg.ld(2'h2, 1'b0, 8'h40);
    prg.ld(2'h1, 1'b0, 8'h3c);
    wrc("fuse lo busy", 1'b0, 1'b0, PROG - 2);
    prg.ld(2'h1, 1'b0, 8'hf7);
    wrc("fuse hi busy", 1'b0, 1'b1, PROG - 2);
    prg.ld(2'h1, 1'b0, 8'he5);
    wrc("fuse ext busy", 1'b1, 1'b0, PROG - 2);
    chk("fuse lo", 8'h3c, f_lo);
    chk("fuse hi", 8'hf7, f_hi);
    chk("fuse ext", 8'he5, f_ex);
    chk("preserve", 8'h01, {7'h0, eep});
    prg.ld(2'h2, 1'b0, 8'h20);
    prg.ld(2'h1, 1'b0, 8'hfc);
    wrc("lock busy", 1'b0, 1'b0, PROG - 2);
    prg.ld(2'h1, 1'b0, 8'hff);
    wrc("lock again", 1'b0, 1'b0, PROG - 2);
    chk("lock kept", 8'hfc, lock);
    prg.ld(2'h2, 1'b0, 8'h04);
    rdc("read fuse lo", 1'b0, 1'b0, 8'h3c);
    rdc("read fuse hi", 1'b1, 1'b1, 8'hf7);
    rdc("read fuse ext", 1'b1, 1'b0, 8'he5);
    rdc("read lock", 1'b0, 1'b1, 8'hfc);
    t_erase(8'hf7);
    prg.ld(2'h2, 1'b0, 8'h03);
    prg.ld(2'h0, 1'b0, 8'h0a);
    rdc("eeprom kept", 1'b0, 1'b0, 8'h5c);
  endtask
  task automatic t_sig();
    prg.ld(2'h2, 1'b0, 8'h08);
    for (int i = 0; i < 4; i++) begin
      prg.ld(2'h0, 1'b0, 8'(i));
      if (i < 3)
        rdc("signature", 1'b0, 1'b0, SIGB + 8'h11 * 8'(i));
      rdc("calibration", 1'b0, 1'b1, CALB + 8'(i));
    end
  endtask
  // ----------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #(100 * 40000);
    bad_count++;
    print_verdict();
  end
  initial begin
    bad_count = 0;
    comparisons = 0;
    rst_b = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_erase(8'hff);
    t_flash();
    t_ee();
    t_fuse();
    t_sig();
    print_verdict();
  end
endmodule // tb
`default_nettype wire
